// ---- rtl/ccs_pkg.sv ----
package ccs_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int unsigned TICK_US     = 1000;
  localparam int unsigned TICK_CYC    = CYC_PER_US * TICK_US;
  localparam int unsigned PULSE_US    = 128;
  localparam int unsigned PULSE_CYC   = CYC_PER_US * PULSE_US;
  localparam int unsigned T32_S       = 32;
  localparam int unsigned T32_TICKS   = T32_S * 1_000_000 / TICK_US;
  localparam int unsigned T15_MIN     = 15;
  localparam int unsigned T15_TICKS   = T15_MIN * 60 * 1_000_000 / TICK_US;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CHG    = 8'h04;
  localparam logic [7:0] OFS_SAFE   = 8'h08;
  localparam logic [7:0] OFS_STATE  = 8'h0c;
  localparam logic [7:0] OFS_EVT    = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;

  // control register fields
  localparam int CTRL_TERM_EN   = 0;
  localparam int CTRL_STAT_EN   = 1;
  localparam int CTRL_PIN_EN    = 2;
  localparam int CTRL_PIN_POL   = 3;
  localparam int CTRL_BOOST     = 4;
  localparam int CTRL_MODE15    = 5;
  localparam int CTRL_TMR_RST   = 6;
  localparam int CTRL_HIZ       = 7;
  localparam int CTRL_CAP_500   = 8;
  localparam int CTRL_W         = 9;
  localparam logic [8:0] CTRL_RST = 9'h00f;

  // charge setting fields: [3:0] current, [7:4] voltage, [10:8] termination level
  localparam int CHG_W          = 11;
  localparam logic [10:0] CHG_RST = 11'h000;

  // safety limits: [3:0] current ceiling, [7:4] voltage ceiling
  localparam int SAFE_W         = 8;
  localparam logic [7:0] SAFE_RST = 8'h00;

  // event bits, shared by status and mask
  localparam int EV_DONE        = 0;
  localparam int EV_FAULT       = 1;
  localparam int EV_EXPIRE      = 2;
  localparam int EV_RECHG       = 3;
  localparam int EV_NOSUP       = 4;
  localparam int EV_W           = 5;
  localparam logic [4:0] MASK_RST = 5'h00;

  // synchronised pin indices
  localparam int PIN_SLC        = 0;
  localparam int PIN_DIS        = 1;
  localparam int PIN_BOOST      = 2;
  localparam int PIN_SUPPLY     = 3;
  localparam int PIN_COND_OK    = 4;
  localparam int PIN_AT_CV      = 5;
  localparam int PIN_AT_TERM    = 6;
  localparam int PIN_RECHG      = 7;
  localparam int PIN_HOT        = 8;
  localparam int PIN_FAULT      = 9;
  localparam int NPIN           = 10;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_COND  = 3'b001,
    ST_CC    = 3'b010,
    ST_CV    = 3'b011,
    ST_DONE  = 3'b100,
    ST_DIS   = 3'b101,
    ST_FAULT = 3'b110
  } ccs_state_t;

endpackage

// ---- rtl/ccs_charger_ctrl.sv ----
// Operation
// - limit input low: defaults, limit writes ignored
// - limit input high: writable until other write
// - disable high stops charge, rails high impedance
// - fifteen-minute mode: disable resets safety timer
// - thirty-two-second mode: disable keeps timer running
// - after the first control write, active boost pin forces boost, overrides software
// - software disables pin, selects pin polarity
// - after reset pin selects input current cap
// - status pulled low while charging and during the fault pulse
// - fault gives one 128 us status pulse
// - status enable bit cleared keeps pin released
// - phases run conditioning, constant current, voltage
// - terminate at selected current when enabled
// - restart charge when battery below recharge
// - supply loss enters sleep or high impedance
// - hot junction lowers commanded charge current
// - safety timer kept alive by host reset
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module ccs_charger_ctrl
  import ccs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // control pins
  input  wire logic        safety_limit_ctrl_n,
  input  wire logic        charge_disable_in,
  input  wire logic        boost_enable_pin,
  // analog indications
  input  wire logic        supply_present,
  input  wire logic        batt_cond_done,
  input  wire logic        batt_at_cv,
  input  wire logic        current_at_term,
  input  wire logic        batt_below_rechg,
  input  wire logic        junction_hot,
  input  wire logic        fault_in,
  // power stage commands
  output logic             charge_en,
  output logic [2:0]       charge_phase,
  output logic [3:0]       charge_current_cmd,
  output logic [3:0]       charge_voltage_cmd,
  output logic [2:0]       term_level,
  output logic             boost_mode,
  output logic             input_current_cap,
  output logic             high_impedance_select,
  output logic             sleep_mode,
  // status pin, open drain
  output logic             stat_o,
  output logic             stat_oe,
  // interrupt
  output logic             irq
);

  // two-stage synchronisers for every outside level
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s;

  assign pin_raw[PIN_SLC]     = safety_limit_ctrl_n;
  assign pin_raw[PIN_DIS]     = charge_disable_in;
  assign pin_raw[PIN_BOOST]   = boost_enable_pin;
  assign pin_raw[PIN_SUPPLY]  = supply_present;
  assign pin_raw[PIN_COND_OK] = batt_cond_done;
  assign pin_raw[PIN_AT_CV]   = batt_at_cv;
  assign pin_raw[PIN_AT_TERM] = current_at_term;
  assign pin_raw[PIN_RECHG]   = batt_below_rechg;
  assign pin_raw[PIN_HOT]     = junction_hot;
  assign pin_raw[PIN_FAULT]   = fault_in;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_s1[gi] <= 1'b0;
          pin_s[gi]  <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s[gi]  <= pin_s1[gi];
        end
      end
    end
  endgenerate

  wire slc_high  = pin_s[PIN_SLC];
  wire dis       = pin_s[PIN_DIS];
  wire supply_ok = pin_s[PIN_SUPPLY];

  // registers
  logic [CTRL_W-1:0] ctrl;
  logic [CHG_W-1:0]  chg;
  logic [SAFE_W-1:0] safe;
  logic [EV_W-1:0]   evt;
  logic [EV_W-1:0]   mask;
  logic              safe_locked;
  logic              cfg_taken;
  ccs_state_t        state;
  ccs_state_t        next_state;

  // apb decode; zero wait states, so every access phase completes
  wire acc      = psel && penable;
  wire setup    = psel && !penable;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_chg  = (paddr == OFS_CHG);
  wire hit_safe = (paddr == OFS_SAFE);
  wire hit_st   = (paddr == OFS_STATE);
  wire hit_evt  = (paddr == OFS_EVT);
  wire hit_mask = (paddr == OFS_MASK);
  wire mapped   = hit_ctrl | hit_chg | hit_safe | hit_st | hit_evt | hit_mask;
  wire wr       = acc && pwrite && mapped;
  wire rd_evt   = acc && !pwrite && hit_evt;
  wire wr_ctrl  = wr && hit_ctrl;
  wire wr_chg   = wr && hit_chg;
  wire wr_mask  = wr && hit_mask;
  wire wr_other = wr && !hit_safe;
  wire tmr_kick = wr_ctrl && pwdata[CTRL_TMR_RST];
  wire safe_ok  = slc_high && !safe_locked;
  wire wr_safe  = wr && hit_safe && safe_ok;

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // safety timer: millisecond tick enable and tick counter
  logic [31:0] presc;
  logic [19:0] tmr;
  logic        expire;
  wire         tick      = (presc == TICK_CYCLES - 1);
  wire         mode15    = ctrl[CTRL_MODE15];
  wire [19:0]  tmr_limit = mode15 ? 20'(T15_TICKS - 1) : 20'(T32_TICKS - 1);
  wire         charging  = (state == ST_COND) || (state == ST_CC) || (state == ST_CV);
  wire         tmr_run   = charging || (state == ST_DIS);
  wire         tmr_clr   = tmr_kick || !tmr_run || (mode15 && dis);
  wire         tmr_hit   = tick && tmr_run && !tmr_clr && (tmr == tmr_limit);

  // prescaler free-runs so the tick spacing never depends on traffic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc <= 32'h0000_0000;
    end else begin
      presc <= tick ? 32'h0000_0000 : presc + 32'h0000_0001;
    end
  end

  // in 32 s mode the disable level is not a clear term, so it keeps counting
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr    <= 20'h00000;
      expire <= 1'b0;
    end else begin
      expire <= tmr_hit;
      if (tmr_clr || tmr_hit) begin
        tmr <= 20'h00000;
      end else if (tick) begin
        tmr <= tmr + 20'h00001;
      end
    end
  end

  // control register; expiry puts control and charge settings back to defaults
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl      <= CTRL_RST;
      chg       <= CHG_RST;
      cfg_taken <= 1'b0;
    end else if (expire) begin
      ctrl      <= CTRL_RST;
      chg       <= CHG_RST;
      cfg_taken <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl                <= pwdata[CTRL_W-1:0];
        ctrl[CTRL_TMR_RST]  <= 1'b0;
        cfg_taken           <= 1'b1;
      end
      if (wr_chg) begin
        chg <= pwdata[CHG_W-1:0];
      end
    end
  end

  // safety limits and their lock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      safe        <= SAFE_RST;
      safe_locked <= 1'b0;
    end else if (!slc_high) begin
      safe        <= SAFE_RST;
      safe_locked <= 1'b0;
    end else begin
      if (wr_safe) begin
        safe <= pwdata[SAFE_W-1:0];
      end
      if (wr_other) begin
        safe_locked <= 1'b1;
      end
    end
  end

  // charge sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF:   if (supply_ok) next_state = dis ? ST_DIS : ST_COND;
      ST_COND:  if (pin_s[PIN_COND_OK]) next_state = ST_CC;
      ST_CC:    if (pin_s[PIN_AT_CV]) next_state = ST_CV;
      ST_CV: begin
        if (ctrl[CTRL_TERM_EN] && pin_s[PIN_AT_TERM]) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:  if (pin_s[PIN_RECHG]) next_state = ST_COND;
      ST_DIS:   if (!dis) next_state = ST_COND;
      ST_FAULT: if (tmr_kick) next_state = ST_COND;
      default:  next_state = ST_OFF;
    endcase
    // priority: supply loss, then disable, then faults
    if (!supply_ok) begin
      next_state = ST_OFF;
    end else if (dis && state != ST_OFF && state != ST_FAULT) begin
      next_state = ST_DIS;
    end else if ((expire || pin_s[PIN_FAULT]) && state != ST_FAULT) begin
      next_state = ST_FAULT;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  wire enter_fault = (next_state == ST_FAULT) && (state != ST_FAULT);
  wire enter_done  = (next_state == ST_DONE) && (state != ST_DONE);
  wire rechg_start = (state == ST_DONE) && (next_state == ST_COND);
  wire lost_supply = (state != ST_OFF) && (next_state == ST_OFF);

  // fault pulse on the status pin, fixed length from entry
  logic [11:0] pulse_cnt;
  wire         pulse_on = (pulse_cnt != 12'h000);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_cnt <= 12'h000;
    end else if (enter_fault) begin
      pulse_cnt <= 12'(PULSE_CYC);
    end else if (pulse_on) begin
      pulse_cnt <= pulse_cnt - 12'h001;
    end
  end

  // sticky events; a read clears only the bits it returned, so an event that
  // lands between the setup capture and the access edge is not lost
  wire [EV_W-1:0] ev_now = {lost_supply, rechg_start, expire, enter_fault, enter_done};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt  <= '0;
      mask <= MASK_RST;
    end else begin
      evt <= (rd_evt ? (evt & ~prdata[EV_W-1:0]) : evt) | ev_now;
      if (wr_mask) begin
        mask <= pwdata[EV_W-1:0];
      end
    end
  end

  assign irq = |(evt & mask);

  // boost pin handling
  wire pin_active  = ctrl[CTRL_PIN_EN] && (pin_s[PIN_BOOST] == ctrl[CTRL_PIN_POL]);
  wire next_boost  = cfg_taken && (pin_active || ctrl[CTRL_BOOST]);
  wire next_cap    = cfg_taken ? ctrl[CTRL_CAP_500] : pin_s[PIN_BOOST];

  // commanded current is capped by the safety limit, halved when hot
  wire [3:0] ilim    = safe[3:0];
  wire [3:0] vlim    = safe[7:4];
  wire [3:0] i_capd  = (chg[3:0] > ilim) ? ilim : chg[3:0];
  wire [3:0] v_capd  = (chg[7:4] > vlim) ? vlim : chg[7:4];
  wire [3:0] i_cmd   = pin_s[PIN_HOT] ? {1'b0, i_capd[3:1]} : i_capd;
  wire       next_hz = dis || ctrl[CTRL_HIZ];

  // status pin drives low only; released means output enable low
  wire stat_pull = ctrl[CTRL_STAT_EN] && (charging || pulse_on);

  // registered power stage and pin outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      charge_en             <= 1'b0;
      charge_phase          <= ST_OFF;
      charge_current_cmd    <= 4'h0;
      charge_voltage_cmd    <= 4'h0;
      term_level            <= 3'h0;
      boost_mode            <= 1'b0;
      input_current_cap     <= 1'b0;
      high_impedance_select <= 1'b0;
      sleep_mode            <= 1'b1;
      stat_oe               <= 1'b0;
    end else begin
      charge_en             <= charging;
      charge_phase          <= state;
      charge_current_cmd    <= charging ? i_cmd : 4'h0;
      charge_voltage_cmd    <= v_capd;
      term_level            <= chg[10:8];
      boost_mode            <= next_boost;
      input_current_cap     <= next_cap;
      high_impedance_select <= next_hz;
      sleep_mode            <= (state == ST_OFF) && !next_hz;
      stat_oe               <= stat_pull;
    end
  end

  assign stat_o = 1'b0;

  // read data is captured in the setup cycle so it is stable for the access
  wire [31:0] rd_mux =
      hit_ctrl ? 32'(ctrl) :
      hit_chg  ? 32'(chg) :
      hit_safe ? 32'(safe) :
      hit_st   ? 32'({cfg_taken, safe_locked, state}) :
      hit_evt  ? 32'(evt) :
      hit_mask ? 32'(mask) : 32'h0000_0000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule

// ---- tb/ccs_host.sv ----
`timescale 1ns/1ps
module ccs_host (
  // bus clock
  input  wire logic        clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // status pin, pulled up on the host board
  input  wire logic        stat_o,
  input  wire logic        stat_oe,
  output logic             stat_line
);
  logic hung;
  // a released pin reads high through the pull-up
  assign stat_line = stat_oe ? stat_o : 1'b1;
  // bus idle from time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata, hung} = '0;
  end
  // setup, then access held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    hung = (i == 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- tb/ccs_charger_ctrl_properties.sv ----
`timescale 1ns/1ps
module ccs_props
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // bus and pins
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       charge_disable_in,
  input wire logic       boost_enable_pin,
  input wire logic       supply_present,
  // outputs under watch
  input wire logic       charge_en,
  input wire logic [2:0] charge_phase,
  input wire logic [3:0] charge_current_cmd,
  input wire logic       boost_mode,
  input wire logic       input_current_cap,
  input wire logic       high_impedance_select,
  input wire logic       sleep_mode,
  input wire logic       stat_o,
  input wire logic       stat_oe
);
  logic        cfg_q;
  logic [11:0] hi_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // first control write hands boost over to software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cfg_q <= 1'b0;
    else if (psel && penable && pwrite && paddr == OFS_CTRL) cfg_q <= 1'b1;
  end
  // low drive length outside charging; wraps harmlessly past 4095
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) hi_cnt <= 12'h0;
    else hi_cnt <= (stat_oe && !charge_en) ? hi_cnt + 12'h1 : 12'h0;
  end
  a_stat_sink: assert property (stat_oe |-> stat_o == 1'b0)
    else $error("status pin driven high");
  a_dis_stop: assert property (charge_disable_in [*6] |-> !charge_en && high_impedance_select)
    else $error("disable did not stop charge");
  a_idle_cmd: assert property (!charge_en |-> charge_current_cmd == 4'h0)
    else $error("current command while idle");
  a_pulse_len: assert property ($fell(stat_oe) && charge_phase == 3'd6 |->
    hi_cnt <= PULSE_CYC && hi_cnt + 2 >= PULSE_CYC)
    else $error("fault pulse length wrong");
  a_pulse_bound: assert property (stat_oe && !charge_en |-> hi_cnt <= PULSE_CYC + 2)
    else $error("fault pulse too long");
  a_por_boost: assert property (!cfg_q |-> !boost_mode)
    else $error("boost before configuration");
  a_por_cap: assert property ((!cfg_q && boost_enable_pin) [*6] |-> input_current_cap)
    else $error("pin did not select high cap");
  a_supply_off: assert property (!supply_present [*6] |->
    !charge_en && (sleep_mode || high_impedance_select))
    else $error("no sleep after supply loss");
  a_phase_step: assert property ($changed(charge_phase) && charge_phase inside {3'd2, 3'd3}
    |-> charge_phase == $past(charge_phase) + 3'd1)
    else $error("charge phase skipped");
endmodule
bind ccs_charger_ctrl ccs_props u_props (.*);

// ---- tb/ccs_charger_ctrl_tb.sv ----
`timescale 1ns/1ps
module ccs_charger_ctrl_tb;
  import ccs_pkg::*;
  localparam int TK  = 2;
  localparam int EXP = T32_TICKS * TK - 20200;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, rnd;
  logic [31:0] pwdata, prdata, q;
  logic        safety_limit_ctrl_n, charge_disable_in, boost_enable_pin, supply_present;
  logic        batt_cond_done, batt_at_cv, current_at_term, batt_below_rechg;
  logic        junction_hot, fault_in, charge_en, boost_mode, input_current_cap;
  logic        high_impedance_select, sleep_mode, stat_o, stat_oe, irq, stat_line;
  logic [2:0]  charge_phase, term_level;
  logic [3:0]  charge_current_cmd, charge_voltage_cmd;
  int          fail_count, checks_done, n;
  ccs_charger_ctrl #(.TICK_CYCLES(TK)) dut (.*);
  ccs_host host (.*);
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // c = {software boost, polarity, pin enable}
  function automatic logic boost_exp(input logic [2:0] c, input logic p);
    return (c[0] && p == c[1]) || c[2];
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // a hung bus counts as a mismatch and ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, q, e);
    if (host.hung) begin
      fail_count++;
      print_verdict;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic wait_ph(input logic [2:0] p, input int lim);
    for (n = 0; n < lim && charge_phase !== p; n++) @(posedge clk);
    if (n == lim) begin
      fail_count++;
      print_verdict;
    end
  endtask
  // pin sync plus state and output registers
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    {sys_rst, boost_enable_pin} = 2'b11;
    {safety_limit_ctrl_n, charge_disable_in, supply_present, batt_cond_done} = '0;
    {batt_at_cv, current_at_term, batt_below_rechg, junction_hot, fault_in} = '0;
    {fail_count, checks_done} = '0;
    rnd = 8'h19;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    settle;
    chk(input_current_cap, 1'b1);
    boost_enable_pin <= 1'b0;
    settle;
    chk(input_current_cap, 1'b0);
    chk(sleep_mode, 1'b1);
    rd_chk(OFS_CTRL, 32'h00f);
    bus(1'b0, 8'h18, 32'h0);
    chk({q[30:0], e}, 32'h1);
    wr(OFS_SAFE, 32'hff);
    rd_chk(OFS_SAFE, 32'h0);
    safety_limit_ctrl_n <= 1'b1;
    settle;
    wr(OFS_SAFE, 32'h5a);
    rd_chk(OFS_SAFE, 32'h5a);
    wr(OFS_CHG, 32'h7c8);
    wr(OFS_SAFE, 32'h33);
    rd_chk(OFS_SAFE, 32'h5a);
    chk(term_level, 3'h7);
    // random pin settings against software boost
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      wr(OFS_CTRL, {23'h0, rnd[0], 3'h0, rnd[3:1], 2'h3});
      boost_enable_pin <= rnd[4];
      settle;
      chk(boost_mode, boost_exp(rnd[3:1], rnd[4]));
      chk(input_current_cap, rnd[0]);
    end
    wr(OFS_CTRL, 32'h003);
    batt_at_cv <= 1'b1;
    supply_present <= 1'b1;
    wait_ph(3'd1, 20);
    settle;
    chk(charge_phase, 3'd1);
    chk(stat_line, 1'b0);
    chk(charge_current_cmd, 4'h8);
    junction_hot <= 1'b1;
    wr(OFS_CTRL, 32'h001);
    settle;
    chk(charge_current_cmd, 4'h4);
    chk(stat_line, 1'b1);
    junction_hot <= 1'b0;
    wr(OFS_CTRL, 32'h003);
    batt_cond_done <= 1'b1;
    wait_ph(3'd3, 20);
    current_at_term <= 1'b1;
    wait_ph(3'd4, 20);
    settle;
    chk({charge_en, stat_line, irq}, 3'b010);
    wr(OFS_MASK, 32'h01);
    @(posedge clk);
    chk(irq, 1'b1);
    rd_chk(OFS_EVT, 32'h01);
    @(posedge clk);
    chk(irq, 1'b0);
    current_at_term <= 1'b0;
    batt_below_rechg <= 1'b1;
    wait_ph(3'd1, 20);
    chk(charge_en, 1'b1);
    batt_below_rechg <= 1'b0;
    charge_disable_in <= 1'b1;
    settle;
    chk({charge_phase, high_impedance_select}, 4'hb);
    charge_disable_in <= 1'b0;
    supply_present <= 1'b0;
    settle;
    chk({charge_phase, sleep_mode}, 4'h1);
    // expiry in 32 s mode; a disable in mid-run must not restart the count
    {batt_cond_done, batt_at_cv} <= 2'b00;
    supply_present <= 1'b1;
    wait_ph(3'd1, 20);
    repeat (20000) @(posedge clk);
    charge_disable_in <= 1'b1;
    repeat (200) @(posedge clk);
    charge_disable_in <= 1'b0;
    wait_ph(3'd6, 50000);
    chk(n > EXP - 10 && n < EXP + 10, 1'b1);
    rd_chk(OFS_CHG, 32'h0);
    rd_chk(OFS_CTRL, 32'h00f);
    bus(1'b0, OFS_EVT, 32'h0);
    chk(q & 32'h6, 32'h6);
    chk({charge_en, stat_line}, 2'b00);
    repeat (PULSE_CYC) @(posedge clk);
    chk(stat_line, 1'b1);
    wr(OFS_CTRL, 32'h043);
    wait_ph(3'd1, 20);
    fault_in <= 1'b1;
    wait_ph(3'd6, 20);
    chk(stat_line, 1'b0);
    print_verdict;
  end
endmodule
